// file: rtcca_pkg.sv
// Package with register map, field positions and timing constants of the calibration and alarm block
package rtcca_pkg;
	localparam logic [7:0] ADDR_CALIB = 8'h08;
	localparam logic [7:0] ADDR_AL_MONTH = 8'h0a;
	localparam logic [7:0] ADDR_AL_DATE = 8'h0b;
	localparam logic [7:0] ADDR_AL_HOUR = 8'h0c;
	localparam logic [7:0] ADDR_AL_MIN = 8'h0d;
	localparam logic [7:0] ADDR_AL_SEC = 8'h0e;
	localparam logic [7:0] ADDR_FLAGS = 8'h0f;
	localparam logic [7:0] ADDR_WAVE = 8'h13;
	localparam logic [7:0] ADDR_TIME_SEC = 8'h01;
	localparam logic [7:0] ADDR_TIME_MIN = 8'h02;
	localparam logic [7:0] ADDR_TIME_HOUR = 8'h03;
	localparam logic [7:0] ADDR_TIME_DATE = 8'h05;
	localparam logic [7:0] ADDR_TIME_MONTH = 8'h06;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam int CAL_SIGN_POS = 5;
	localparam int FT_POS = 6;
	localparam int HALT_POS = 7;
	localparam int AFE_POS = 7;
	localparam int WAVE_EN_POS = 6;
	localparam int ABE_POS = 5;
	localparam int RPT_HI_POS = 7;
	localparam int RPT5_POS = 6;
	localparam int AF_POS = 6;
	localparam int DRAIN_POS = 3;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [4:0] RPT_SECOND = 5'h1f;
	localparam logic [4:0] RPT_MINUTE = 5'h1e;
	localparam logic [4:0] RPT_HOUR = 5'h1c;
	localparam logic [4:0] RPT_DAY = 5'h18;
	localparam logic [4:0] RPT_MONTH = 5'h10;
	localparam logic [4:0] RPT_YEAR = 5'h00;
	localparam int OSC_HZ = 32768;
	localparam int REF_CLK_HZ = 125000000;
	localparam int STAGE_DIV = 256;
	localparam int SLOW_CYCLES = 128;
	localparam int FAST_CYCLES = 256;
	localparam int CAL_CYCLE_MIN = 64;
	localparam int TEST_HZ = 512;
	localparam logic [5:0] TEST_HALF = 6'((OSC_HZ / TEST_HZ) / 2);
	localparam logic [5:0] MIN_LAST = 6'h3b;
	localparam logic [5:0] CYC_LAST = 6'(CAL_CYCLE_MIN - 1);
	localparam logic [6:0] STAGE_TOP = 7'(OSC_HZ / STAGE_DIV - 1);
	localparam logic [7:0] PRE_TOP = 8'(STAGE_DIV - 1);
	localparam logic [8:0] SLOW_STEPS = 9'(SLOW_CYCLES);
	localparam logic [8:0] FAST_STEPS = 9'(FAST_CYCLES);
	typedef struct packed {
		logic [7:0] month;
		logic [7:0] date;
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] second;
	} rtcca_time_t;
	typedef enum logic [2:0] {
		RTCCA_IDLE = 3'b001,
		RTCCA_WAIT = 3'b010,
		RTCCA_DONE = 3'b100
	} rtcca_bus_t;
endpackage

// file: rtcca_top.sv
// Calibration divider, frequency test output and alarm logic with Avalon-MM register access
`timescale 1ns/10ps
// Function
// - Calibration adds or removes counts at the divide-by-256 stage.
// - Five-bit calibration magnitude in bits 4..0 of register 08h.
// - Bit 5 of 08h sets direction, one slows down.
// - 64-minute cycle; one second shortened 128 or lengthened 256 cycles.
// - Magnitude N modifies first 2N minutes, never more than 62.
// - Test pin toggles at 512 Hz when halt clear, test set, wave off.
// - Test frequency does not depend on calibration value.
// - Open-drain select makes the test pin only pull low.
// - Frequency test bit clears when main power goes down.
// - Alarm month, date, hour, minute, second held at 0Ah..0Eh.
// - Repeat mask selects second, minute, hour, day, month or year period.
// - Undefined repeat masks behave as once per second.
// - Match under the repeat criteria sets the alarm flag.
// - Match with interrupt enable drives the interrupt pin low.
// - Pointer resting on flags address withholds flag and interrupt.
// - Flags read releases interrupt; cleared flag seen on later read.
// - In backup, interrupt needs both backup enable and interrupt enable.
// - Power-up clears backup and interrupt enables; alarm sets flag only.
// - Time and alarm registers hold BCD, control registers binary.
module rtcca_top
	import rtcca_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic osc_tick,
	input wire logic main_power_ok,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic wave_test_pin_o,
	output logic wave_test_pin_oe,
	output logic irq_n_o,
	output logic irq_n_oe,
	output logic second_tick
);
	logic [7:0] calib_reg;
	logic [7:0] al_reg [5];
	logic [7:0] wave_reg;
	logic [7:0] tm_reg [5];
	logic [7:0] pointer_reg;
	logic alarm_hit_flag_reg;
	logic irq_reg;
	logic pending_reg;
	logic halt_reg;
	logic tick_d_reg;
	logic [31:0] rdata_reg;
	rtcca_bus_t bus_reg;
	logic [7:0] pre_reg;
	logic [6:0] stage_reg;
	logic [5:0] cyc_min_reg;
	logic [8:0] adj_reg;
	logic adj_done_reg;
	logic [5:0] test_cnt_reg;
	logic test_level_reg;
	logic sec_pulse;
	logic match;
	logic [4:0] repeat_mask_bits;
	logic freq_test_bit;
	logic osc_halt_bit;
	logic wave_output_enable;
	logic output_drain_select;
	logic alarm_irq_enable;
	logic backup_alarm_enable;
	logic access;
	logic [7:0] rd_byte;

	function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] last, input logic [7:0] first);
		logic [7:0] r;
		r = first;
		if (v != last)
		begin
			if (v[3:0] == 4'h9)
				r = {v[7:4] + 4'h1, 4'h0};
			else
				r = {v[7:4], v[3:0] + 4'h1};
		end
		return r;
	endfunction

	function automatic logic [4:0] cmp_sel(input logic [4:0] rpt);
		logic [4:0] s;
		case (rpt)
			RPT_YEAR: s = 5'h1f;
			RPT_MONTH: s = 5'h0f;
			RPT_DAY: s = 5'h07;
			RPT_HOUR: s = 5'h03;
			RPT_MINUTE: s = 5'h01;
			default: s = 5'h00;
		endcase
		return s;
	endfunction

	// Halt sits beside the seconds count so that no repeat bit can stop the oscillator
	assign osc_halt_bit = halt_reg;
	assign freq_test_bit = calib_reg[FT_POS];
	assign alarm_irq_enable = al_reg[0][AFE_POS];
	assign wave_output_enable = al_reg[0][WAVE_EN_POS];
	assign backup_alarm_enable = al_reg[0][ABE_POS];
	assign output_drain_select = wave_reg[DRAIN_POS];
	assign repeat_mask_bits = {al_reg[1][RPT5_POS], al_reg[1][RPT_HI_POS], al_reg[2][RPT_HI_POS],
		al_reg[3][RPT_HI_POS], al_reg[4][RPT_HI_POS]};
	assign access = (avs_read || avs_write) && bus_reg == RTCCA_IDLE;
	assign avs_waitrequest = (avs_read || avs_write) && bus_reg != RTCCA_DONE;
	assign avs_readdata = rdata_reg;
	assign second_tick = sec_pulse;

	// Two wait cycles: data registered at the end of the first, waitrequest drops in the third
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			bus_reg <= RTCCA_IDLE;
		else
		begin
			case (bus_reg)
				RTCCA_IDLE: bus_reg <= (avs_read || avs_write) ? RTCCA_WAIT : RTCCA_IDLE;
				RTCCA_WAIT: bus_reg <= RTCCA_DONE;
				RTCCA_DONE: bus_reg <= RTCCA_IDLE;
				default: bus_reg <= RTCCA_IDLE;
			endcase
		end
	end

	always_comb
	begin
		case (avs_address)
			ADDR_CALIB: rd_byte = calib_reg;
			ADDR_AL_MONTH: rd_byte = al_reg[0];
			ADDR_AL_DATE: rd_byte = al_reg[1];
			ADDR_AL_HOUR: rd_byte = al_reg[2];
			ADDR_AL_MIN: rd_byte = al_reg[3];
			ADDR_AL_SEC: rd_byte = al_reg[4];
			ADDR_FLAGS: rd_byte = {1'b0, alarm_hit_flag_reg, 6'h00};
			ADDR_WAVE: rd_byte = wave_reg;
			ADDR_TIME_SEC: rd_byte = {halt_reg, tm_reg[4][6:0]};
			ADDR_TIME_MIN: rd_byte = tm_reg[3];
			ADDR_TIME_HOUR: rd_byte = tm_reg[2];
			ADDR_TIME_DATE: rd_byte = tm_reg[1];
			ADDR_TIME_MONTH: rd_byte = tm_reg[0];
			ADDR_STATUS: rd_byte = {2'h0, cyc_min_reg};
			default: rd_byte = RESET_BYTE;
		endcase
	end

	// Read data is captured at the access so a flags read returns the value before its clear
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_reg <= 32'h0000_0000;
		else if (access && avs_read)
			rdata_reg <= {24'h000000, rd_byte};
	end

	// Last accessed address stands as the register pointer
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			pointer_reg <= RESET_BYTE;
		else if (access)
			pointer_reg <= avs_address;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			calib_reg <= RESET_BYTE;
			wave_reg <= RESET_BYTE;
			halt_reg <= 1'b0;
			for (int i = 0; i < 5; i++)
				al_reg[i] <= RESET_BYTE;
		end
		else
		begin
			if (access && avs_write)
			begin
				case (avs_address)
					ADDR_CALIB: calib_reg <= avs_writedata[7:0];
					ADDR_WAVE: wave_reg <= avs_writedata[7:0];
					ADDR_TIME_SEC: halt_reg <= avs_writedata[HALT_POS];
					ADDR_AL_MONTH: al_reg[0] <= avs_writedata[7:0];
					ADDR_AL_DATE: al_reg[1] <= avs_writedata[7:0];
					ADDR_AL_HOUR: al_reg[2] <= avs_writedata[7:0];
					ADDR_AL_MIN: al_reg[3] <= avs_writedata[7:0];
					ADDR_AL_SEC: al_reg[4] <= avs_writedata[7:0];
					default: calib_reg <= calib_reg;
				endcase
			end
			if (!main_power_ok)
				calib_reg[FT_POS] <= 1'b0;
		end
	end

	// Divide-by-256 prescaler with calibration steps: shorten by 128 or stretch by 256 osc cycles
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_reg <= RESET_BYTE;
			stage_reg <= 7'h00;
			adj_reg <= 9'h000;
			adj_done_reg <= 1'b0;
		end
		else if (osc_tick && !osc_halt_bit)
		begin
			if (adj_reg != 9'h000)
				adj_reg <= adj_reg - 9'h001;
			else if (pre_reg == PRE_TOP)
			begin
				pre_reg <= RESET_BYTE;
				if (stage_reg == STAGE_TOP)
				begin
					stage_reg <= 7'h00;
					adj_done_reg <= 1'b0;
				end
				else
				begin
					stage_reg <= stage_reg + 7'h01;
					// One second per affected minute, in the first 2N minutes of 64
					if (!adj_done_reg && tm_reg[4] == RESET_BYTE && stage_reg == 7'h00
						&& cyc_min_reg < {calib_reg[4:0], 1'b0} && cyc_min_reg < 6'(62))
					begin
						adj_done_reg <= 1'b1;
						if (calib_reg[CAL_SIGN_POS])
							adj_reg <= FAST_STEPS;
						else
						begin
							pre_reg <= 8'(SLOW_CYCLES);
							adj_reg <= 9'h000;
						end
					end
				end
			end
			else
				pre_reg <= pre_reg + 8'h01;
		end
	end

	assign sec_pulse = osc_tick && !osc_halt_bit && adj_reg == 9'h000 && pre_reg == PRE_TOP && stage_reg == STAGE_TOP;

	// BCD time counters and 64-minute calibration cycle counter
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tm_reg[4] <= RESET_BYTE;
			tm_reg[3] <= RESET_BYTE;
			tm_reg[2] <= RESET_BYTE;
			tm_reg[1] <= 8'h01;
			tm_reg[0] <= 8'h01;
			cyc_min_reg <= 6'h00;
		end
		else if (access && avs_write && avs_address >= ADDR_TIME_SEC && avs_address <= ADDR_TIME_MONTH)
		begin
			case (avs_address)
				ADDR_TIME_SEC: tm_reg[4] <= {1'b0, avs_writedata[6:0]};
				ADDR_TIME_MIN: tm_reg[3] <= {1'b0, avs_writedata[6:0]};
				ADDR_TIME_HOUR: tm_reg[2] <= {2'h0, avs_writedata[5:0]};
				ADDR_TIME_DATE: tm_reg[1] <= {2'h0, avs_writedata[5:0]};
				ADDR_TIME_MONTH: tm_reg[0] <= {3'h0, avs_writedata[4:0]};
				default: tm_reg[4] <= tm_reg[4];
			endcase
		end
		else if (sec_pulse)
		begin
			tm_reg[4] <= bcd_inc(tm_reg[4], 8'h59, 8'h00);
			if (tm_reg[4] == 8'h59)
			begin
				tm_reg[3] <= bcd_inc(tm_reg[3], 8'h59, 8'h00);
				cyc_min_reg <= (cyc_min_reg == CYC_LAST) ? 6'h00 : cyc_min_reg + 6'h01;
				if (tm_reg[3] == 8'h59)
				begin
					tm_reg[2] <= bcd_inc(tm_reg[2], 8'h23, 8'h00);
					if (tm_reg[2] == 8'h23)
					begin
						tm_reg[1] <= bcd_inc(tm_reg[1], 8'h31, 8'h01);
						if (tm_reg[1] == 8'h31)
							tm_reg[0] <= bcd_inc(tm_reg[0], 8'h12, 8'h01);
					end
				end
			end
		end
	end

	// Compare each field under the mask of the repeat mode
	always_comb
	begin
		logic [4:0] sel;
		sel = cmp_sel(repeat_mask_bits);
		match = 1'b1;
		if (sel[0] && tm_reg[4][6:0] != al_reg[4][6:0])
			match = 1'b0;
		if (sel[1] && tm_reg[3][6:0] != al_reg[3][6:0])
			match = 1'b0;
		if (sel[2] && tm_reg[2][5:0] != al_reg[2][5:0])
			match = 1'b0;
		if (sel[3] && tm_reg[1][5:0] != al_reg[1][5:0])
			match = 1'b0;
		if (sel[4] && tm_reg[0][4:0] != al_reg[0][4:0])
			match = 1'b0;
	end

	// A match while the pointer rests on flags waits in pending until the pointer leaves
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			alarm_hit_flag_reg <= 1'b0;
			irq_reg <= 1'b0;
			pending_reg <= 1'b0;
			tick_d_reg <= 1'b0;
		end
		else
		begin
			tick_d_reg <= sec_pulse;
			if (access && avs_read && avs_address == ADDR_FLAGS)
			begin
				alarm_hit_flag_reg <= 1'b0;
				irq_reg <= 1'b0;
			end
			// One cycle after the tick, so the counters already show the new second
			if (tick_d_reg && match)
				pending_reg <= 1'b1;
			else if (pointer_reg != ADDR_FLAGS && pending_reg)
			begin
				pending_reg <= 1'b0;
				alarm_hit_flag_reg <= 1'b1;
				// Backup needs both enables
				if (alarm_irq_enable && (main_power_ok || backup_alarm_enable))
					irq_reg <= 1'b1;
			end
		end
	end

	// 512 Hz test wave from the raw oscillator, untouched by calibration
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			test_cnt_reg <= 6'h00;
			test_level_reg <= 1'b0;
		end
		else if (osc_tick && !osc_halt_bit)
		begin
			if (test_cnt_reg == TEST_HALF - 6'h01)
			begin
				test_cnt_reg <= 6'h00;
				test_level_reg <= ~test_level_reg;
			end
			else
				test_cnt_reg <= test_cnt_reg + 6'h01;
		end
	end

	always_comb
	begin
		logic active;
		active = !osc_halt_bit && freq_test_bit && !wave_output_enable;
		wave_test_pin_o = active ? test_level_reg : 1'b0;
		if (output_drain_select)
		begin
			wave_test_pin_o = 1'b0;
			wave_test_pin_oe = active && !test_level_reg;
		end
		else
			wave_test_pin_oe = active;
	end

	assign irq_n_o = 1'b0;
	assign irq_n_oe = irq_reg;
endmodule

// file: rtcca_assertions.sv
// Port checker for the calibration and alarm block
`timescale 1ns/10ps
module rtcca_assertions
	import rtcca_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic osc_tick,
	input wire logic main_power_ok,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic wave_test_pin_o,
	input wire logic wave_test_pin_oe,
	input wire logic irq_n_o,
	input wire logic irq_n_oe,
	input wire logic second_tick
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic [15:0] osc_cnt_reg;
	logic seen_reg;
	// Oscillator ticks per second; the first second after reset is skipped
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			osc_cnt_reg <= 16'h0000;
			seen_reg <= 1'b0;
		end
		else if (second_tick)
		begin
			osc_cnt_reg <= 16'h0000;
			seen_reg <= 1'b1;
		end
		else if (osc_tick)
			osc_cnt_reg <= osc_cnt_reg + 16'h0001;
	end
	sequence answer_s;
		avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	sequence flags_read_s;
		avs_read && !avs_waitrequest && avs_address == ADDR_FLAGS;
	endsequence
	chk_bus_answer: assert property ($rose(avs_read || avs_write) |-> answer_s)
		else $error("bus answer latency wrong");
	chk_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	chk_irq_drain: assert property (irq_n_oe |-> !irq_n_o)
		else $error("interrupt pin driven high");
	chk_flag_release: assert property (flags_read_s |=> !irq_n_oe [*3])
		else $error("interrupt kept after flags read");
	chk_irq_hold: assert property ($fell(irq_n_oe) |-> $past(avs_address) == ADDR_FLAGS)
		else $error("interrupt dropped without flags read");
	chk_irq_withheld: assert property ($rose(irq_n_oe) |-> avs_address != ADDR_FLAGS)
		else $error("interrupt raised with pointer on flags");
	chk_second_len: assert property (second_tick && seen_reg |-> osc_cnt_reg inside {[16'h7f58:16'h814c]})
		else $error("second length out of range");
	chk_tick_pulse: assert property (second_tick |=> !second_tick [*8])
		else $error("second tick too long");
endmodule

// file: rtcca_host.sv
// Host processor model driving the register bus
`timescale 1ns/10ps
module rtcca_host (
	input wire logic ref_clk,
	input wire logic avs_waitrequest,
	input wire logic [31:0] avs_readdata,
	output logic [7:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata
);
	initial
	begin
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
	end
	// Address stays put after release so the pointer is not disturbed
	task automatic access(input logic wr_en, input logic [7:0] addr, input logic [7:0] data, output logic [7:0] rdata);
		@(posedge ref_clk);
		avs_address <= addr;
		avs_read <= !wr_en;
		avs_write <= wr_en;
		avs_writedata <= {24'h000000, data};
		do
			@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0);
		rdata = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
endmodule

// file: testbench.sv
// Top-level bench for the calibration and alarm block
`timescale 1ns/10ps
module testbench;
	import rtcca_pkg::*;
	typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} rtcca_row_t;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic osc_tick = 1'b0;
	logic main_power_ok = 1'b1;
	logic [7:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata;
	logic wave_test_pin_o, wave_test_pin_oe, irq_n_o, irq_n_oe, second_tick;
	logic [7:0] rdata;
	int n_mismatch = 0;
	int checks = 0;
	int cyc = 0;
	int t_tick = 0;
	int t_prev = 0;
	// Pull-up level of the shared test pin
	wire test_lvl = wave_test_pin_oe ? wave_test_pin_o : 1'b1;
	rtcca_row_t rows [9] = '{'{ADDR_CALIB, 8'h3f, 8'h3f}, '{ADDR_AL_MONTH, 8'h12, 8'h12}, '{ADDR_AL_DATE, 8'h31, 8'h31},
		'{ADDR_AL_HOUR, 8'h23, 8'h23}, '{ADDR_AL_MIN, 8'h59, 8'h59}, '{ADDR_AL_SEC, 8'h59, 8'h59},
		'{ADDR_WAVE, 8'h08, 8'h08}, '{ADDR_FLAGS, 8'h40, 8'h00}, '{8'h40, 8'hff, 8'h00}};
	always #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk) cyc <= cyc + 1;
	rtcca_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .osc_tick(osc_tick), .main_power_ok(main_power_ok),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wave_test_pin_o(wave_test_pin_o),
		.wave_test_pin_oe(wave_test_pin_oe), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .second_tick(second_tick));
	rtcca_host host_u (.ref_clk(ref_clk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_u.access(1'b1, a, d, rdata);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		host_u.access(1'b0, a, 8'h00, rdata);
		chk(16'(rdata), 16'(e));
	endtask
	// One osc tick per clock, so a half period is counted in clocks
	task automatic half_period;
		logic lvl;
		int cnt;
		cnt = 0;
		@(posedge ref_clk);
		lvl = test_lvl;
		while (test_lvl === lvl && cnt < 200)
		begin
			@(posedge ref_clk);
			cnt++;
		end
		lvl = test_lvl;
		cnt = 0;
		do
		begin
			@(posedge ref_clk);
			cnt++;
		end
		while (test_lvl === lvl && cnt < 200);
		chk(16'(cnt), 16'(TEST_HALF));
	endtask
	task automatic wait_tick;
		int i;
		i = 0;
		while (second_tick !== 1'b1 && i < 40000)
		begin
			@(posedge ref_clk);
			i++;
		end
		t_prev = t_tick;
		t_tick = cyc;
		chk(16'(second_tick), 16'h0001);
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic tally_and_finish;
		$display("Checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		osc_tick <= 1'b1;
		foreach (rows[i])
		begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr, rows[i].exp);
		end
		rst_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(ADDR_CALIB, 8'h00);
		rd(ADDR_AL_MONTH, 8'h00);
		wr(ADDR_CALIB, 8'h40);
		half_period();
		wr(ADDR_CALIB, 8'h7f);
		half_period();
		wr(ADDR_WAVE, 8'h08);
		half_period();
		chk(16'(wave_test_pin_o), 16'h0000);
		main_power_ok <= 1'b0;
		repeat (2) @(posedge ref_clk);
		main_power_ok <= 1'b1;
		rd(ADDR_CALIB, 8'h3f);
		wr(ADDR_CALIB, 8'h00);
		wr(ADDR_WAVE, 8'h00);
		// Once-per-minute mask, match on second 01 twice
		wr(ADDR_AL_DATE, 8'hc0);
		wr(ADDR_AL_HOUR, 8'h80);
		wr(ADDR_AL_MIN, 8'h80);
		wr(ADDR_AL_SEC, 8'h01);
		wr(ADDR_AL_MONTH, 8'h80);
		rd(ADDR_FLAGS, 8'h00);
		wait_tick();
		chk(16'(irq_n_oe), 16'h0000);
		rd(ADDR_CALIB, 8'h00);
		repeat (3) @(posedge ref_clk);
		chk(16'(irq_n_oe), 16'h0001);
		rd(ADDR_FLAGS, 8'h40);
		@(posedge ref_clk);
		chk(16'(irq_n_oe), 16'h0000);
		rd(ADDR_FLAGS, 8'h00);
		main_power_ok <= 1'b0;
		// Second 0 of minute 0 is shortened by a negative step of one
		wr(ADDR_AL_SEC, 8'h01);
		wr(ADDR_CALIB, 8'h01);
		wr(ADDR_TIME_SEC, 8'h00);
		rd(8'h10, 8'h00);
		wait_tick();
		chk(16'(t_tick - t_prev), 16'(OSC_HZ - SLOW_CYCLES));
		chk(16'(irq_n_oe), 16'h0000);
		main_power_ok <= 1'b1;
		rd(ADDR_FLAGS, 8'h40);
		for (int a = 11; a < 15; a++)
			wr(8'(a), 8'h00);
		rd(8'h10, 8'h00);
		tally_and_finish();
	end
	initial
	begin
		repeat (90000) @(posedge ref_clk);
		n_mismatch++;
		tally_and_finish();
	end
endmodule
bind rtcca_top rtcca_assertions chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .osc_tick(osc_tick),
	.main_power_ok(main_power_ok), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.wave_test_pin_o(wave_test_pin_o), .wave_test_pin_oe(wave_test_pin_oe), .irq_n_o(irq_n_o),
	.irq_n_oe(irq_n_oe), .second_tick(second_tick));
